// ==== bus_command_delay_gate.sv ====
// Command strobe gating with AXI4-Lite control
// Operation
// - Delay input first sampled on the tick ending the status state.
// - While delay sampled high, strobe stays off; resample every tick.
// - Local mode: strobe goes active on the tick delay is seen low.
// - Multimaster mode: strobe never earlier than the multimaster timing.
// - Ready may end the cycle while the delay still holds the strobe.
// - Cycle ended without command: no strobe, enable and direction idle.
// - Multimaster read and acknowledge strobes start one tick later.
// - Multimaster write strobes start two ticks later.
// - Delay input affects only strobes, not latch, cascade, enable, direction.
// - Cycle enable latched low: no command, delay and ready ignored.
`timescale 1ns/1ps
module bus_command_delay_gate
  import cmd_gate_pkg::*;
#(
  parameter int TICK_DIV = BUS_TICK_DIV
) (
  input wire logic mclk,
  input wire logic nrst,
  input bus_status_t bus_status,
  input wire logic ready_n,
  input wire logic command_delay_input,
  input wire logic cycle_enable_latched,
  output strobes_t command_strobes_n,
  output logic data_enable_out,
  output logic transfer_direction_out,
  output logic address_latch_out,
  output logic cascade_enable_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic tick;
  cycle_t new_type;
  cycle_t cyc_type;
  gate_state_t state;
  logic multimaster_mode_select;
  logic cen_ok;
  logic dly_seen;
  logic cmd_on;
  logic [1:0] tc_ticks;
  logic [1:0] need;
  logic [SKIP_W-1:0] skips;

  bus_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .mclk(mclk),
    .nrst(nrst),
    .tick(tick)
  );

  cycle_decode u_dec (
    .status(bus_status),
    .cycle(new_type)
  );

  // Cycle classification
  wire type_read = (cyc_type == CYC_MRD) || (cyc_type == CYC_IORD) || (cyc_type == CYC_IACK);
  wire type_write = (cyc_type == CYC_MWR) || (cyc_type == CYC_IOWR);
  wire new_write = (new_type == CYC_MWR) || (new_type == CYC_IOWR);
  wire start = tick && (state == ST_IDLE) && (new_type != CYC_NONE);
  wire ts_end = tick && (state == ST_STATUS) && (cyc_type != CYC_HALT);
  wire halt_end = tick && (state == ST_STATUS) && (cyc_type == CYC_HALT);
  wire cmd_tick = tick && (state == ST_CMD);
  wire restart = cmd_tick && !cen_ok && (new_type != CYC_NONE);
  wire ready_end = cmd_tick && cen_ok && !ready_n;
  wire cycle_live = ts_end ? cycle_enable_latched : cen_ok;
  wire next_dly = ts_end ? !command_delay_input : (dly_seen || !command_delay_input);
  wire [1:0] tick_inc = (tc_ticks == TICKS_MAX) ? tc_ticks : tc_ticks + 2'h1;
  wire [1:0] next_ticks = ts_end ? 2'h0 : tick_inc;
  wire [1:0] mode_need = !multimaster_mode_select ? NEED_LOCAL :
                         (type_write ? NEED_MM_WRITE : NEED_MM_READ);
  wire [1:0] next_need = ts_end ? mode_need : need;
  wire next_cmd_on = (ts_end || cmd_tick) && !ready_end && cycle_live && next_dly
                     && (next_ticks >= next_need);

  // One strobe for the latched type
  strobes_t next_strobes;
  always_comb
  begin
    next_strobes = STROBES_IDLE;
    next_strobes.interrupt_ack_strobe_n = !(next_cmd_on && cyc_type == CYC_IACK);
    next_strobes.io_read_strobe_n = !(next_cmd_on && cyc_type == CYC_IORD);
    next_strobes.io_write_strobe_n = !(next_cmd_on && cyc_type == CYC_IOWR);
    next_strobes.memory_read_strobe_n = !(next_cmd_on && cyc_type == CYC_MRD);
    next_strobes.memory_write_strobe_n = !(next_cmd_on && cyc_type == CYC_MWR);
  end

  // Control outputs ignore the delay input
  wire next_data_en = start ? (new_write && !multimaster_mode_select) :
                  ts_end ? (cycle_enable_latched && (type_read || type_write)) :
                  (ready_end || restart) ? 1'b0 : data_enable_out;
  wire next_dir = ts_end ? !(cycle_enable_latched && type_read) :
                  (ready_end || restart) ? 1'b1 : transfer_direction_out;

  gate_state_t next_state;
  always_comb
  begin
    case (state)
      ST_IDLE: next_state = start ? ST_STATUS : ST_IDLE;
      ST_STATUS: next_state = halt_end ? ST_IDLE : (ts_end ? ST_CMD : ST_STATUS);
      ST_CMD: next_state = restart ? ST_STATUS : (ready_end ? ST_IDLE : ST_CMD);
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      cyc_type <= CYC_NONE;
      cen_ok <= 1'b0;
      dly_seen <= 1'b0;
      cmd_on <= 1'b0;
      tc_ticks <= 2'h0;
      need <= NEED_LOCAL;
      command_strobes_n <= STROBES_IDLE;
      data_enable_out <= 1'b0;
      transfer_direction_out <= 1'b1;
    end
    else if (tick)
    begin
      state <= next_state;
      cyc_type <= (start || restart) ? new_type : cyc_type;
      cen_ok <= ts_end ? cycle_enable_latched : cen_ok;
      dly_seen <= next_dly;
      cmd_on <= next_cmd_on;
      tc_ticks <= next_ticks;
      need <= next_need;
      command_strobes_n <= next_strobes;
      data_enable_out <= next_data_en;
      transfer_direction_out <= next_dir;
    end
  end

  // Address latch and cascade enable
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      address_latch_out <= 1'b0;
      cascade_enable_out <= 1'b0;
    end
    else if (tick)
    begin
      address_latch_out <= (start || restart) ? (new_type != CYC_HALT) : 1'b0;
      cascade_enable_out <= (start || restart) ? (new_type == CYC_IACK) :
                            (ts_end ? cascade_enable_out : 1'b0);
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      skips <= '0;
    else if (ready_end && !cmd_on)
      skips <= skips + SKIP_W'(1);
  end

  // AXI4-Lite slave
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire next_aw_held = (aw_held || aw_take) && !do_write;
  wire next_w_held = (w_held || w_take) && !do_write;
  wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  wire wr_ctrl = do_write && (aw_addr == REG_CTRL) && w_strb[0];
  wire wr_known = (aw_addr == REG_CTRL) || (aw_addr == REG_STATUS) || (aw_addr == REG_SKIPS);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_known = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS)
                  || (s_axi_araddr == REG_SKIPS);
  wire [31:0] status_word = {18'h0, skips == '0, cen_ok, dly_seen, cmd_on, 1'b0,
                             cyc_type, 2'h0, state, tc_ticks};
  wire [31:0] rd_word = (s_axi_araddr == REG_CTRL) ? {31'h0, multimaster_mode_select} :
                        (s_axi_araddr == REG_STATUS) ? status_word :
                        (s_axi_araddr == REG_SKIPS) ? {{(32 - SKIP_W){1'b0}}, skips} : 32'h0;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      multimaster_mode_select <= CTRL_MM_RESET;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= aw_take ? s_axi_awaddr : aw_addr;
      w_data <= w_take ? s_axi_wdata : w_data;
      w_strb <= w_take ? s_axi_wstrb : w_strb;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= do_write ? (wr_known ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp;
      multimaster_mode_select <= wr_ctrl ? w_data[CTRL_MM_BIT] : multimaster_mode_select;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= ar_take ? rd_word : s_axi_rdata;
      s_axi_rresp <= ar_take ? (rd_known ? RESP_OKAY : RESP_SLVERR) : s_axi_rresp;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  wire any_strobe = (command_strobes_n != STROBES_IDLE);
  sequence s_ts_end_low;
    ts_end && !command_delay_input && cycle_enable_latched && !multimaster_mode_select;
  endsequence

  property p_first_sample;
    ts_end |=> (dly_seen == !$past(command_delay_input));
  endproperty
  a_first_sample: assert property (p_first_sample) else $error("delay not sampled at status end");

  property p_hold_off;
    any_strobe |-> dly_seen;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("strobe active before delay seen low");

  property p_local_now;
    s_ts_end_low |=> any_strobe;
  endproperty
  a_local_now: assert property (p_local_now) else $error("local strobe not immediate");

  property p_mm_read;
    $rose(cmd_on) && multimaster_mode_select && type_read |-> (tc_ticks >= NEED_MM_READ);
  endproperty
  a_mm_read: assert property (p_mm_read) else $error("multimaster read strobe early");

  property p_mm_write;
    $rose(cmd_on) && multimaster_mode_select && type_write |-> (tc_ticks >= NEED_MM_WRITE);
  endproperty
  a_mm_write: assert property (p_mm_write) else $error("multimaster write strobe early");

  property p_skip_idle;
    ready_end && !cmd_on |=> !any_strobe && !data_enable_out && transfer_direction_out
                             && state == ST_IDLE;
  endproperty
  a_skip_idle: assert property (p_skip_idle) else $error("terminated cycle not idled");

  property p_den_free;
    ts_end && cycle_enable_latched && type_read |=> data_enable_out && !transfer_direction_out;
  endproperty
  a_den_free: assert property (p_den_free) else $error("read enable or direction wrong");

  property p_disabled;
    state == ST_CMD && !cen_ok |-> !cmd_on && !any_strobe && !data_enable_out;
  endproperty
  a_disabled: assert property (p_disabled) else $error("command while cycle disabled");

  property p_onehot;
    any_strobe |-> $onehot(~command_strobes_n) && cmd_on;
  endproperty
  a_onehot: assert property (p_onehot) else $error("strobe not single");
endmodule : bus_command_delay_gate

// ==== cmd_gate_pkg.sv ====
// Shared types and constants for the command-delay gate
package cmd_gate_pkg;
  localparam int MCLK_NS = 10;
  localparam int BUS_CLK_NS = 120;
  localparam int BUS_TICK_DIV = (BUS_CLK_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SKIPS = 4'h8;
  localparam int CTRL_MM_BIT = 0;
  localparam logic CTRL_MM_RESET = 1'b0;
  localparam int SKIP_W = 16;
  localparam logic [1:0] NEED_LOCAL = 2'h0;
  localparam logic [1:0] NEED_MM_READ = 2'h1;
  localparam logic [1:0] NEED_MM_WRITE = 2'h2;
  localparam logic [1:0] TICKS_MAX = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CYC_NONE, CYC_IACK, CYC_IORD, CYC_IOWR, CYC_HALT, CYC_MRD, CYC_MWR
  } cycle_t;

  typedef enum logic [1:0] {ST_IDLE, ST_STATUS, ST_CMD} gate_state_t;

  typedef struct packed {
    logic mem_io;
    logic s1_n;
    logic s0_n;
  } bus_status_t;

  typedef struct packed {
    logic interrupt_ack_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic memory_read_strobe_n;
    logic memory_write_strobe_n;
  } strobes_t;

  localparam strobes_t STROBES_IDLE = 5'h1f;
endpackage : cmd_gate_pkg

// ==== bus_tick_gen.sv ====
// Divider giving one-cycle bus-clock tick enables
`timescale 1ns/1ps
module bus_tick_gen #(
  parameter int DIV = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] count;
  wire wrap = (count == CW'(DIV - 1));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= wrap ? '0 : count + CW'(1);
      tick <= wrap;
    end
  end
endmodule : bus_tick_gen

// ==== cycle_decode.sv ====
// Status pins to bus cycle type
`timescale 1ns/1ps
module cycle_decode
  import cmd_gate_pkg::*;
(
  input bus_status_t status,
  output cycle_t cycle
);
  always_comb
  begin
    case ({status.mem_io, status.s1_n, status.s0_n})
      3'h0: cycle = CYC_IACK;
      3'h1: cycle = CYC_IORD;
      3'h2: cycle = CYC_IOWR;
      3'h4: cycle = CYC_HALT;
      3'h5: cycle = CYC_MRD;
      3'h6: cycle = CYC_MWR;
      default: cycle = CYC_NONE;
    endcase
  end
endmodule : cycle_decode

// ==== far_slave.sv ====
// Memory and I/O slave answering command strobes with ready
`timescale 1ns/1ps
module far_slave
  import cmd_gate_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input strobes_t command_strobes_n,
  input wire logic [3:0] wait_cycles,
  input wire logic abort,
  output logic ready_n
);
  logic [3:0] cnt;
  wire selected = command_strobes_n != STROBES_IDLE;

  // Ready after wait_cycles of strobe, or at once on a commanded early end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 4'h0;
      ready_n <= 1'b1;
    end
    else
    begin
      cnt <= selected ? cnt + 4'h1 : 4'h0;
      ready_n <= !(abort || (selected && cnt >= wait_cycles));
    end
  end
endmodule : far_slave

// ==== bus_command_delay_gate_bench.sv ====
// Self-checking bench for the command-delay gate
`timescale 1ns/1ps
module bus_command_delay_gate_bench
  import cmd_gate_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  bus_status_t bus_status = 3'h3;
  logic command_delay_input = 1'b0;
  logic cycle_enable_latched = 1'b1;
  logic abort = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic ph = 1'b1;
  logic mm = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ready_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  strobes_t strobes_n;
  logic data_en, dir, ale, cascade_en;
  int n_errors = 0;
  int compares = 0;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};

  bus_command_delay_gate #(.TICK_DIV(2)) u_bus_command_delay_gate (
    .mclk(mclk), .nrst(nrst), .bus_status(bus_status), .ready_n(ready_n),
    .command_delay_input(command_delay_input), .cycle_enable_latched(cycle_enable_latched),
    .command_strobes_n(strobes_n), .data_enable_out(data_en), .transfer_direction_out(dir),
    .address_latch_out(ale), .cascade_enable_out(cascade_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  far_slave u_far_slave (
    .mclk(mclk), .nrst(nrst), .command_strobes_n(strobes_n),
    .wait_cycles(wait_cycles), .abort(abort), .ready_n(ready_n)
  );

  always #5 mclk = ~mclk;

  // Mirrors the divider phase: tick edges are those where ph was high
  always @(posedge mclk or negedge nrst)
    ph <= nrst ? ~ph : 1'b1;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic step();
    do @(posedge mclk); while (ph !== 1'b1);
  endtask : step

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_on;
    logic w_on;
    @(posedge mclk);
    aw_on = 1'b1;
    w_on = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_on || w_on)
    begin
      @(posedge mclk);
      if (aw_on && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
  endtask : axi_rd

  function automatic strobes_t strobe_for(input logic [2:0] code);
    case (code)
      3'h0: return 5'h0f;
      3'h1: return 5'h17;
      3'h2: return 5'h1b;
      3'h5: return 5'h1d;
      3'h6: return 5'h1e;
      default: return STROBES_IDLE;
    endcase
  endfunction : strobe_for

  // One bus cycle: d ticks of delay held, w slave wait cycles, ab ends it early
  task automatic run_cycle(input logic [2:0] code, input int d, input logic cen,
                           input logic ab, input logic [3:0] w);
    strobes_t s;
    logic wr;
    logic live;
    int extra;
    int first;
    int last;
    s = strobe_for(code);
    wr = code == 3'h2 || code == 3'h6;
    live = cen && s != STROBES_IDLE;
    extra = mm ? (wr ? 2 : 1) : 0;
    first = 2 + (extra > d ? extra : d);
    last = (live && !ab) ? first + 1 + (w + 1) / 2 : 4;
    step();
    bus_status <= code;
    command_delay_input <= d > 0;
    cycle_enable_latched <= cen;
    wait_cycles <= w;
    step();
    bus_status <= 3'h3;
    #1;
    chk("ale", ale, code != 3'h4);
    chk("cascade_en", cascade_en, code == 3'h0);
    for (int t = 2; t <= last; t++)
    begin
      step();
      if (t + 1 == 2 + d || t == last)
        command_delay_input <= 1'b0;
      abort <= ab && t == 3;
      #1;
      chk("strobes", strobes_n, (live && !ab && t >= first && t < last) ? s : STROBES_IDLE);
      if (t == 2)
      begin
        chk("data_en", data_en, live);
        chk("dir", dir, !(live && !wr));
      end
      if (t == last)
      begin
        chk("data_en end", data_en, 1'b0);
        chk("dir end", dir, 1'b1);
      end
    end
  endtask : run_cycle

  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
    axi_rd(4'hc, 32'h0, RESP_SLVERR);
    axi_wr(4'hc, 32'h1, RESP_SLVERR);
    for (int m = 0; m < 2; m++)
    begin
      foreach (codes[i])
        run_cycle(codes[i], 0, 1'b1, 1'b0, 4'h0);
      run_cycle(3'h2, 1, 1'b1, 1'b0, 4'h0);
      axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
      mm = 1'b1;
    end
    axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
    run_cycle(3'h5, 2, 1'b1, 1'b0, 4'h4);
    run_cycle(3'h6, 9, 1'b1, 1'b1, 4'h0);
    run_cycle(3'h4, 0, 1'b1, 1'b0, 4'h0);
    run_cycle(3'h1, 0, 1'b0, 1'b0, 4'h0);
    axi_rd(REG_SKIPS, 32'h1, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h0000088b, RESP_OKAY);
    run_cycle(3'h5, 0, 1'b1, 1'b0, 4'h0);
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
endmodule : bus_command_delay_gate_bench
